// ===== pkg/popc_pkg.sv
// constants, types and the mode decoder for the port-one pin block
package popc_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 4;                 // pins on the port
  localparam int MODE_W    = 2;                 // bits per mode field
  localparam int DATA_W    = 32;                // apb data width
  localparam int ADDR_W    = 12;                // apb address width
  localparam int IDX_W     = 8;                 // register index width
  localparam int REG_W     = 8;                 // software register width

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_PIN_MODE      = 8'hEF;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE    = 8'hF0;
  localparam logic [IDX_W-1:0] IDX_PULLUP_ENABLE = 8'hF1;
  localparam logic [IDX_W-1:0] IDX_OUT_DATA      = 8'hF4;
  localparam logic [IDX_W-1:0] IDX_PIN_STATE     = 8'hF5;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS    = 8'hF6;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK      = 8'hF7;
  localparam logic [1:0]       BYTE_LANE_OFS     = 2'h0;
  localparam logic [1:0]       ADDR_TOP_ZERO     = 2'h0;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int PIN_FIELD_MSB = 3;             // implemented per-pin bits
  localparam int MODE_MSB      = 7;             // top of the mode register
  localparam logic [REG_W-1:0]     PIN_MODE_RST      = 8'h00;
  localparam logic [PIN_COUNT-1:0] IRQ_ENABLE_RST    = 4'h0;
  localparam logic [PIN_COUNT-1:0] PULLUP_ENABLE_RST = 4'h0;
  localparam logic [PIN_COUNT-1:0] OUT_DATA_RST      = 4'h0;
  localparam logic [PIN_COUNT-1:0] IRQ_MASK_RST      = 4'h0;
  localparam logic [PIN_COUNT-1:0] IRQ_STATUS_RST    = 4'h0;
  localparam logic [DATA_W-1:0]    PRDATA_RST        = 32'h0000_0000;

  // ---------------------------------------------------------------
  // pin modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SCHMITT    = 2'b00,
    MODE_PUSH_PULL  = 2'b01,
    MODE_OPEN_DRAIN = 2'b10,
    MODE_ANALOG     = 2'b11
  } popc_mode_t;

  // picks the mode field of one pin out of the mode register
  function automatic popc_mode_t popcModeOf(input logic [REG_W-1:0] modes,
                                            input int pin);
    popcModeOf = popc_mode_t'(modes[pin*MODE_W +: MODE_W]);
  endfunction : popcModeOf

endpackage : popc_pkg

// ===== verilog/popc_pin_cell.sv
// one pad controller: turns a pin mode into registered pad controls
`timescale 1ns/100ps
module popc_pin_cell
  import popc_pkg::*;
(
  input  wire logic       sys_clk,   // core clock
  input  wire logic       rst,       // async reset, active high
  input  wire popc_mode_t mode,      // mode field of this pin
  input  wire logic       outBit,    // output value for this pin
  input  wire logic       pullupBit, // pull-up enable for this pin
  output logic            padOut,    // value driven onto the pad
  output logic            padOeN,    // output enable, low drives
  output logic            pullupEn,  // pull-up resistor connect
  output logic            analogSel, // pad routed to the converter
  output logic            schmittEn  // digital input buffer on
);

  logic padOutNext;
  logic padOeNNext;
  logic analogSelNext;
  logic schmittEnNext;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  always_comb begin
    padOutNext    = 1'b0;
    padOeNNext    = 1'b1;
    analogSelNext = 1'b0;
    schmittEnNext = 1'b0;
    case (mode)
      MODE_SCHMITT: begin
        schmittEnNext = 1'b1;
      end
      MODE_PUSH_PULL: begin
        padOutNext    = outBit;
        padOeNNext    = 1'b0;
        schmittEnNext = 1'b1;
      end
      MODE_OPEN_DRAIN: begin
        // only a zero is driven, a one leaves the pad to the pull-up
        padOutNext    = 1'b0;
        padOeNNext    = outBit;
        schmittEnNext = 1'b1;
      end
      default: begin
        // analog: input buffer off so a mid-rail level burns no current
        analogSelNext = 1'b1;
      end
    endcase
  end

  // pad controls from flip-flops so the pad sees no decode glitches
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      padOut    <= 1'b0;
      padOeN    <= 1'b1;
      pullupEn  <= 1'b0;
      analogSel <= 1'b0;
      schmittEn <= 1'b0;
    end else begin
      padOut    <= padOutNext;
      padOeN    <= padOeNNext;
      pullupEn  <= pullupBit;
      analogSel <= analogSelNext;
      schmittEn <= schmittEnNext;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_push_pull_drive: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_PUSH_PULL |=> !padOeN && padOut == $past(outBit))
    else $error("push-pull pin not driving its output value");

  a_open_drain_low: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_OPEN_DRAIN |=> !padOut && padOeN == $past(outBit))
    else $error("open-drain pin drives other than a low");

  a_analog_release: assert property (
    @(posedge sys_clk) disable iff (rst)
    mode == MODE_ANALOG |=> padOeN && analogSel && !schmittEn)
    else $error("analog pin not released to the converter");

endmodule : popc_pin_cell

// ===== verilog/popc_port_one.sv
// port-one pin configuration block: apb registers, pads and interrupt
`timescale 1ns/100ps
module popc_port_one
  import popc_pkg::*;
(
  input  wire logic                 sys_clk,     // core clock, 20 MHz
  input  wire logic                 rst,         // async reset, active high
  input  wire logic                 psel,        // apb select
  input  wire logic                 penable,     // apb access phase
  input  wire logic                 pwrite,      // apb write when high
  input  wire logic [ADDR_W-1:0]    paddr,       // apb byte address
  input  wire logic [DATA_W-1:0]    pwdata,      // apb write data
  output logic      [DATA_W-1:0]    prdata,      // apb read data
  output logic                      pready,      // apb transfer done
  output logic                      pslverr,     // apb unmapped address
  input  wire logic [PIN_COUNT-1:0] pinIn,       // pad input levels
  output logic      [PIN_COUNT-1:0] pinOut,      // pad output values
  output logic      [PIN_COUNT-1:0] pinOeN,      // pad enables, low drives
  output logic      [PIN_COUNT-1:0] pinPullupEn, // pull-up connects
  output logic      [PIN_COUNT-1:0] pinAnalogSel,// pads to converter
  output logic      [PIN_COUNT-1:0] pinSchmittEn,// input buffers on
  output logic                      irq          // level interrupt
);
  import popc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [REG_W-1:0]     pinModeReg,      pinModeNext;
  logic [PIN_COUNT-1:0] irqEnableReg,    irqEnableNext;
  logic [PIN_COUNT-1:0] pullupEnableReg, pullupEnableNext;
  logic [PIN_COUNT-1:0] outDataReg,      outDataNext;
  logic [PIN_COUNT-1:0] irqMaskReg,      irqMaskNext;
  logic [PIN_COUNT-1:0] irqStatusReg,    irqStatusNext;
  logic [PIN_COUNT-1:0] pinLevelReg,     pinLevelNext;
  logic [PIN_COUNT-1:0] pinPrevReg,      pinPrevNext;
  logic [DATA_W-1:0]    prdataReg,       prdataNext;
  logic                 preadyReg,       preadyNext;
  logic                 pslverrReg,      pslverrNext;
  logic                 irqReg,          irqNext;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic             accessWait;  // access phase, answer not yet given
  logic             xferDone;    // edge at which pready is sampled high
  logic             wrDone;      // write takes effect now
  logic [IDX_W-1:0] regIdx;
  logic             addrOk;
  logic             hitMode, hitIrqEn, hitPullup, hitOut;
  logic             hitState, hitStatus, hitMask, hitAny;
  logic [REG_W-1:0] readMux;

  assign accessWait = psel && penable && !preadyReg;
  assign xferDone   = psel && penable && preadyReg;
  assign wrDone     = xferDone && pwrite;
  assign regIdx     = paddr[IDX_W+1:2];
  assign addrOk     = (paddr[ADDR_W-1:IDX_W+2] == ADDR_TOP_ZERO) &&
                      (paddr[1:0] == BYTE_LANE_OFS);

  // register select and read mux; misaligned or far addresses miss
  always_comb begin
    hitMode   = 1'b0;
    hitIrqEn  = 1'b0;
    hitPullup = 1'b0;
    hitOut    = 1'b0;
    hitState  = 1'b0;
    hitStatus = 1'b0;
    hitMask   = 1'b0;
    readMux   = 8'h00;
    if (!addrOk) begin
      readMux = 8'h00;
    end else if (regIdx == IDX_PIN_MODE) begin
      hitMode = 1'b1;
      readMux = pinModeReg;
    end else if (regIdx == IDX_IRQ_ENABLE) begin
      hitIrqEn = 1'b1;
      readMux  = {4'h0, irqEnableReg};
    end else if (regIdx == IDX_PULLUP_ENABLE) begin
      hitPullup = 1'b1;
      readMux   = {4'h0, pullupEnableReg};
    end else if (regIdx == IDX_OUT_DATA) begin
      hitOut  = 1'b1;
      readMux = {4'h0, outDataReg};
    end else if (regIdx == IDX_PIN_STATE) begin
      hitState = 1'b1;
      readMux  = {4'h0, pinLevelReg};
    end else if (regIdx == IDX_IRQ_STATUS) begin
      hitStatus = 1'b1;
      readMux   = {4'h0, irqStatusReg};
    end else if (regIdx == IDX_IRQ_MASK) begin
      hitMask = 1'b1;
      readMux = {4'h0, irqMaskReg};
    end
  end

  assign hitAny = hitMode || hitIrqEn || hitPullup || hitOut ||
                  hitState || hitStatus || hitMask;

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  logic [PIN_COUNT-1:0] pinEvent;
  logic [PIN_COUNT-1:0] digitalIn;
  logic [PIN_COUNT-1:0] statusClear;

  // an analog pin has its input buffer off, so it raises no events
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      digitalIn[i] = (popcModeOf(pinModeReg, i) != MODE_ANALOG);
    end
  end

  always_comb begin
    // one wait state: pready rises in the second access cycle
    preadyNext  = accessWait;
    prdataNext  = accessWait ? {24'h00_0000, readMux} : PRDATA_RST;
    pslverrNext = accessWait && !hitAny;

    pinModeNext      = pinModeReg;
    irqEnableNext    = irqEnableReg;
    pullupEnableNext = pullupEnableReg;
    outDataNext      = outDataReg;
    irqMaskNext      = irqMaskReg;
    statusClear      = 4'h0;

    if (wrDone && hitMode) begin
      pinModeNext = pwdata[MODE_MSB:0];
    end
    if (wrDone && hitIrqEn) begin
      // upper bits are dropped, they hold no state
      irqEnableNext = pwdata[PIN_FIELD_MSB:0];
    end
    if (wrDone && hitPullup) begin
      pullupEnableNext = pwdata[PIN_FIELD_MSB:0];
    end
    if (wrDone && hitOut) begin
      outDataNext = pwdata[PIN_FIELD_MSB:0];
    end
    if (wrDone && hitMask) begin
      irqMaskNext = pwdata[PIN_FIELD_MSB:0];
    end
    if (wrDone && hitStatus) begin
      statusClear = pwdata[PIN_FIELD_MSB:0];
    end

    // any level change of an enabled digital pin is an event
    pinLevelNext = pinIn;
    pinPrevNext  = pinLevelReg;
    pinEvent     = (pinLevelReg ^ pinPrevReg) & irqEnableReg &
                   digitalIn;
    // a new event beats a write-one-to-clear in the same cycle
    irqStatusNext = (irqStatusReg & ~statusClear) | pinEvent;
    // taken from next values so irq tracks status with no lag
    irqNext = |(irqStatusNext & irqMaskNext);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinModeReg      <= PIN_MODE_RST;
      irqEnableReg    <= IRQ_ENABLE_RST;
      pullupEnableReg <= PULLUP_ENABLE_RST;
      outDataReg      <= OUT_DATA_RST;
      irqMaskReg      <= IRQ_MASK_RST;
      irqStatusReg    <= IRQ_STATUS_RST;
      pinLevelReg     <= 4'h0;
      pinPrevReg      <= 4'h0;
      prdataReg       <= PRDATA_RST;
      preadyReg       <= 1'b0;
      pslverrReg      <= 1'b0;
      irqReg          <= 1'b0;
    end else begin
      pinModeReg      <= pinModeNext;
      irqEnableReg    <= irqEnableNext;
      pullupEnableReg <= pullupEnableNext;
      outDataReg      <= outDataNext;
      irqMaskReg      <= irqMaskNext;
      irqStatusReg    <= irqStatusNext;
      pinLevelReg     <= pinLevelNext;
      pinPrevReg      <= pinPrevNext;
      prdataReg       <= prdataNext;
      preadyReg       <= preadyNext;
      pslverrReg      <= pslverrNext;
      irqReg          <= irqNext;
    end
  end

  assign prdata  = prdataReg;
  assign pready  = preadyReg;
  assign pslverr = pslverrReg;
  assign irq     = irqReg;

  // ---------------------------------------------------------------
  // pad cells
  // ---------------------------------------------------------------
  for (genvar g = 0; g < PIN_COUNT; g++) begin : gPin
    popc_pin_cell uCell (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .mode      (popcModeOf(pinModeReg, g)),
      .outBit    (outDataReg[g]),
      .pullupBit (pullupEnableReg[g]),
      .padOut    (pinOut[g]),
      .padOeN    (pinOeN[g]),
      .pullupEn  (pinPullupEn[g]),
      .analogSel (pinAnalogSel[g]),
      .schmittEn (pinSchmittEn[g])
    );
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_mode_write_lands: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wrDone && hitMode) |=> pinModeReg == $past(pwdata[7:0]))
    else $error("mode write not stored");

  a_pin_mode_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    (popcModeOf(pinModeReg, 3) == MODE_PUSH_PULL)
      |=> !pinOeN[3] && pinOut[3] == $past(outDataReg[3]))
    else $error("pin three mode field not applied");

  a_irq_enable_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    (irqEnableReg == 4'h0 && irqStatusReg == 4'h0)
      |=> irqStatusReg == 4'h0)
    else $error("event latched from a disabled pin");

  a_irq_enable_rst: assert property (
    @(posedge sys_clk)
    rst |=> irqEnableReg == 4'h0)
    else $error("interrupt enables not cleared by reset");

  a_pullup_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    ##1 pinPullupEn == $past(pullupEnableReg))
    else $error("pull-up pads do not follow their enables");

  a_pullup_rst: assert property (
    @(posedge sys_clk)
    rst |=> pullupEnableReg == 4'h0 && pinPullupEn == 4'h0)
    else $error("pull-ups not released by reset");

  a_irq_en_upper: assert property (
    @(posedge sys_clk) disable iff (rst)
    (accessWait && !pwrite && hitIrqEn)
      |=> pready && prdata[7:4] == 4'h0 &&
          prdata[3:0] == $past(irqEnableReg))
    else $error("interrupt enable upper bits not zero");

  a_pullup_upper: assert property (
    @(posedge sys_clk) disable iff (rst)
    (accessWait && !pwrite && hitPullup)
      |=> pready && prdata[7:4] == 4'h0 &&
          prdata[3:0] == $past(pullupEnableReg))
    else $error("pull-up enable upper bits not zero");

  a_open_drain_pin: assert property (
    @(posedge sys_clk) disable iff (rst)
    (popcModeOf(pinModeReg, 0) == MODE_OPEN_DRAIN && outDataReg[0])
      |=> pinOeN[0])
    else $error("open-drain pin zero driven while output is one");

  a_apb_one_wait: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(psel && penable) |-> !pready ##1 pready)
    else $error("apb answer not after exactly one wait");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (rst)
    irq == |(irqStatusReg & irqMaskReg))
    else $error("interrupt line disagrees with status and mask");

  // an event arriving with a clear must still leave its bit set
  a_status_set_wins: assert property (
    @(posedge sys_clk) disable iff (rst)
    (|pinEvent) |=> (irqStatusReg & $past(pinEvent)) == $past(pinEvent))
    else $error("pin event lost against a clear");

  // status bit 0, once set, stays until software writes a one to it
  a_status_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    (irqStatusReg[0] && !statusClear[0]) |=> irqStatusReg[0])
    else $error("status bit dropped without a clear");

  // unmapped addresses answer with an error and zero data
  a_unmapped_refused: assert property (
    @(posedge sys_clk) disable iff (rst)
    (accessWait && !hitAny) |=> pready && pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");

endmodule : popc_port_one

// ===== tb/popc_pad_world.sv
// behavioural model of the circuitry hanging on the four port pins
`timescale 1ns/100ps
module popc_pad_world
  import popc_pkg::*;
(
  input  wire logic                 sys_clk,     // core clock
  input  wire logic [PIN_COUNT-1:0] pinOut,      // design pad values
  input  wire logic [PIN_COUNT-1:0] pinOeN,      // design enables, low drives
  input  wire logic [PIN_COUNT-1:0] pinPullupEn, // design pull-up connects
  input  wire logic [PIN_COUNT-1:0] extDrive,    // outside source active
  input  wire logic [PIN_COUNT-1:0] extVal,      // outside source value
  output logic      [PIN_COUNT-1:0] pinLevel     // resolved wire levels
);
  logic [PIN_COUNT-1:0] heldLevel;  // last level some party drove

  // -------------------------------------------------------------
  // wire resolution
  // -------------------------------------------------------------
  // a floating pin shows the inverse of its last driven level so that
  // an undriven pad never reads as a lucky match
  always_comb begin
    for (int n = 0; n < PIN_COUNT; n++) begin
      if (pinOeN[n] == 1'b0) begin
        pinLevel[n] = pinOut[n];
      end else if (extDrive[n]) begin
        pinLevel[n] = extVal[n];
      end else if (pinPullupEn[n]) begin
        pinLevel[n] = 1'b1;
      end else begin
        pinLevel[n] = ~heldLevel[n];
      end
    end
  end

  // remember the level only while something really drives the pin
  always @(posedge sys_clk) begin
    for (int n = 0; n < PIN_COUNT; n++) begin
      if (!pinOeN[n] || extDrive[n] || pinPullupEn[n]) begin
        heldLevel[n] <= pinLevel[n];
      end
    end
  end

  initial heldLevel = '0;

endmodule : popc_pad_world

// ===== tb/test_port_one_pin_config_irq_pullup.sv
// self-checking bench for the port-one pin configuration block
`timescale 1ns/100ps
module test_port_one_pin_config_irq_pullup;
  import popc_pkg::*;

  logic                 sys_clk;
  logic                 rst;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [ADDR_W-1:0]    paddr;
  logic [DATA_W-1:0]    pwdata;
  logic [DATA_W-1:0]    prdata;
  logic                 pready;
  logic                 pslverr;
  logic [PIN_COUNT-1:0] pinIn;
  logic [PIN_COUNT-1:0] pinOut;
  logic [PIN_COUNT-1:0] pinOeN;
  logic [PIN_COUNT-1:0] pinPullupEn;
  logic [PIN_COUNT-1:0] pinAnalogSel;
  logic [PIN_COUNT-1:0] pinSchmittEn;
  logic                 irq;
  logic [PIN_COUNT-1:0] extDrive;
  logic [PIN_COUNT-1:0] extVal;
  logic [3:0]           outv;
  logic [3:0]           expOe;
  logic [3:0]           expLv;
  logic [3:0]           expAn;
  logic [DATA_W-1:0]    rdat;
  logic                 err;
  int                   mismatches;
  int                   checked;

  // -------------------------------------------------------------
  // clock and instances
  // -------------------------------------------------------------
  // 20 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  popc_port_one u_popc_port_one (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
    .pinOeN(pinOeN), .pinPullupEn(pinPullupEn),
    .pinAnalogSel(pinAnalogSel), .pinSchmittEn(pinSchmittEn), .irq(irq)
  );

  popc_pad_world u_popc_pad_world (
    .sys_clk(sys_clk), .pinOut(pinOut), .pinOeN(pinOeN),
    .pinPullupEn(pinPullupEn), .extDrive(extDrive), .extVal(extVal),
    .pinLevel(pinIn)
  );

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; a dead slave is caught by the watchdog, not here
  task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                     input logic [DATA_W-1:0] wdat,
                     output logic [DATA_W-1:0] rd, output logic er);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {ADDR_TOP_ZERO, idx, BYTE_LANE_OFS};
    pwdata  <= wdat;
    @(posedge sys_clk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wrReg(input logic [IDX_W-1:0] idx,
                       input logic [DATA_W-1:0] d);
    apb(1'b1, idx, d, rdat, err);
  endtask : wrReg

  task automatic rdChk(input logic [IDX_W-1:0] idx,
                       input logic [DATA_W-1:0] exp);
    apb(1'b0, idx, '0, rdat, err);
    check(rdat, exp);
    check({31'h0, err}, 32'h0);
  endtask : rdChk

  // pads in order: enables, driven level, converter, schmitt
  task automatic padChk(input logic [15:0] exp);
    check({16'h0, pinOeN, pinOut | pinOeN, pinAnalogSel, pinSchmittEn},
          {16'h0, exp});
  endtask : padChk

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    results();
  end

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    extDrive = 4'h0;
    extVal = 4'h0;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    settle(2);
    padChk(16'hFF0F);
    rdChk(IDX_PIN_MODE, 32'h0);
    rdChk(IDX_IRQ_ENABLE, 32'h0);
    rdChk(IDX_PULLUP_ENABLE, 32'h0);
    check({28'h0, pinPullupEn}, 32'h0);
    // upper bits of the enables hold nothing
    wrReg(IDX_IRQ_ENABLE, 32'hFF);
    rdChk(IDX_IRQ_ENABLE, 32'h0F);
    wrReg(IDX_PULLUP_ENABLE, 32'hFF);
    rdChk(IDX_PULLUP_ENABLE, 32'h0F);
    settle(2);
    check({28'h0, pinPullupEn}, 32'hF);
    wrReg(IDX_PULLUP_ENABLE, 32'hF5);
    settle(2);
    check({28'h0, pinPullupEn}, 32'h5);
    // every encoding on all pins, with both output values
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 2; v++) begin
        outv = v ? 4'hF : 4'h0;
        wrReg(IDX_PIN_MODE, {24'h0, {4{m[1:0]}}});
        wrReg(IDX_OUT_DATA, {28'h0, outv});
        settle(2);
        // open-drain drives (enable low) only where the output is zero
        expOe = (m == 1) ? 4'h0 : (m == 2) ? outv : 4'hF;
        expLv = (m == 1 || m == 2) ? outv : 4'hF;
        expAn = (m == 3) ? 4'hF : 4'h0;
        padChk({expOe, expLv, expAn, ~expAn});
      end
    end
    // distinct field per pin shows each field's position
    wrReg(IDX_PIN_MODE, 32'hE4);
    wrReg(IDX_OUT_DATA, 32'h0);
    rdChk(IDX_PIN_MODE, 32'hE4);
    settle(2);
    padChk(16'h9987);
    // events: pin1 disabled, pin3 analog, pins 0 and 2 count
    wrReg(IDX_PIN_MODE, 32'hC0);
    extDrive <= 4'hF;
    wrReg(IDX_IRQ_ENABLE, 32'h0D);
    wrReg(IDX_IRQ_MASK, 32'hF);
    settle(4);
    wrReg(IDX_IRQ_STATUS, 32'hF);
    rdChk(IDX_IRQ_STATUS, 32'h0);
    @(posedge sys_clk);
    extVal <= 4'hF;
    settle(5);
    rdChk(IDX_PIN_STATE, 32'hF);
    rdChk(IDX_IRQ_STATUS, 32'h5);
    check({31'h0, irq}, 32'h1);
    wrReg(IDX_IRQ_STATUS, 32'h5);
    settle(2);
    check({31'h0, irq}, 32'h0);
    // a masked event still sets status but keeps the line low
    wrReg(IDX_IRQ_MASK, 32'h0);
    @(posedge sys_clk);
    extVal <= 4'h0;
    settle(5);
    rdChk(IDX_IRQ_STATUS, 32'h5);
    check({31'h0, irq}, 32'h0);
    wrReg(IDX_IRQ_MASK, 32'h1);
    settle(2);
    check({31'h0, irq}, 32'h1);
    // an unmapped index is refused and reads zero
    apb(1'b0, 8'hF2, '0, rdat, err);
    check(rdat, 32'h0);
    check({31'h0, err}, 32'h1);
    // a second reset in mid-run clears both enable sets
    @(posedge sys_clk);
    rst <= 1'b1;
    settle(3);
    check({31'h0, irq}, 32'h0);
    @(posedge sys_clk);
    rst <= 1'b0;
    settle(2);
    rdChk(IDX_IRQ_ENABLE, 32'h0);
    rdChk(IDX_PULLUP_ENABLE, 32'h0);
    check({28'h0, pinPullupEn}, 32'h0);
    results();
  end

endmodule : test_port_one_pin_config_irq_pullup
